/* logic/iwd_cfg.svh */
`ifndef IWD_CFG_SVH
`define IWD_CFG_SVH
// ----------------------------------------
// Register byte addresses (index * 4)
// ----------------------------------------
`define IWD_IDX_UNIT      8'h52
`define IWD_IDX_VALUE     8'h53
`define IWD_IDX_CONFIG    8'h54
`define IWD_IDX_CTRL      8'h55
`define IWD_IDX_IRQ_STAT  8'h56
`define IWD_IDX_IRQ_MASK  8'h57
`define IWD_ADDR_UNIT     12'h148
`define IWD_ADDR_VALUE    12'h14C
`define IWD_ADDR_CONFIG   12'h150
`define IWD_ADDR_CTRL     12'h154
`define IWD_ADDR_IRQ_STAT 12'h158
`define IWD_ADDR_IRQ_MASK 12'h15C
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define IWD_UNIT_SEC_BIT  7
`define IWD_CFG_GAME_BIT  0
`define IWD_CFG_KBD_BIT   1
`define IWD_CFG_MOUSE_BIT 2
`define IWD_CFG_RSVD_BIT  3
`define IWD_CTRL_STAT_BIT 0
`define IWD_CTRL_FORCE_BIT 2
`define IWD_UNIT_MASK     8'h80
`define IWD_CFG_MASK      8'hF7
`define IWD_RESET_VALUE   8'h00
`define IWD_IRQ_INVALID   4'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define IWD_CLOCK_MHZ     250
`define IWD_SECOND_CYCLES (`IWD_CLOCK_MHZ * 1000000)
`define IWD_SEC_PER_MIN   60
`endif

/* logic/iwd_pkg.sv */
package iwd_pkg;
    // Restart sources from the system
    typedef struct packed {
        logic game;
        logic kbd;
        logic mouse;
    } iwd_kick_s;
    // Counter state
    typedef enum logic [0:0] {
        IWD_IDLE,
        IWD_COUNT
    } iwd_state_e;
endpackage : iwd_pkg

/* logic/iwd_watchdog.sv */
// Behaviour
// - Unit bit 7 selects seconds, else minutes
// - Timeout value is unsigned unit count
// - Value zero keeps watchdog disabled
// - Nonzero N gives N units period
// - Game port access restarts when enabled
// - Keyboard interrupt restarts when enabled
// - Mouse interrupt restarts when enabled
// - Config bits 7:4 route timeout IRQ
// - Reserved unit and config bits read zero
// - Status bit shows timeout occurred
// - Force bit causes timeout, self-clears
`timescale 1ns/10ps
`default_nettype none
`include "iwd_cfg.svh"
module iwd_watchdog #(
    parameter int unsigned SECOND_CYCLES = `IWD_SECOND_CYCLES
) (
    // Clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RESETN,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Restart sources, one-cycle pulses
    input  wire iwd_pkg::iwd_kick_s KICK,
    // Legacy IRQ lines 1..15 except 2, bits 0 and 2 unused
    output logic      [15:0]       IRQ_LINE,
    // Summary interrupt
    output logic                   IRQ
);
    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;
    // Release passes two flops before use
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic acc;
    logic wr;
    logic rd;
    // Access phase strobes
    assign acc = PSEL && PENABLE && PREADY;
    assign wr  = acc && PWRITE;
    assign rd  = acc && !PWRITE;

    // Known address test, used for the error response
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `IWD_ADDR_UNIT) || (a == `IWD_ADDR_VALUE) ||
                 (a == `IWD_ADDR_CONFIG) || (a == `IWD_ADDR_CTRL) ||
                 (a == `IWD_ADDR_IRQ_STAT) || (a == `IWD_ADDR_IRQ_MASK);
    endfunction : mapped

    // ----------------------------------------
    // Registers and timer state
    // ----------------------------------------
    // Present values
    logic [7:0]  unit_sel;
    logic [7:0]  tmo_value;
    logic [7:0]  config_reg;
    logic        tmo_status;
    logic        force_pend;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [31:0] tick_cnt;
    logic [5:0]  sec_cnt;
    logic [7:0]  unit_cnt;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [15:0] irq_line_q;
    logic        irq_q;
    iwd_pkg::iwd_state_e state;

    // Next values
    logic [7:0]  next_unit_sel;
    logic [7:0]  next_tmo_value;
    logic [7:0]  next_config_reg;
    logic        next_tmo_status;
    logic        next_force_pend;
    logic [1:0]  next_irq_stat;
    logic [1:0]  next_irq_mask;
    logic [31:0] next_tick_cnt;
    logic [5:0]  next_sec_cnt;
    logic [7:0]  next_unit_cnt;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [15:0] next_irq_line;
    logic        next_irq;
    iwd_pkg::iwd_state_e next_state;

    // Internal strobes
    logic kick;
    logic sec_tick;
    logic unit_tick;
    logic expire;
    logic tmo_event;
    logic [3:0] route;

    // Restart qualification
    assign kick = (KICK.game  && config_reg[`IWD_CFG_GAME_BIT])
               || (KICK.kbd   && config_reg[`IWD_CFG_KBD_BIT])
               || (KICK.mouse && config_reg[`IWD_CFG_MOUSE_BIT]);
    assign sec_tick  = (tick_cnt == SECOND_CYCLES - 1);
    assign unit_tick = sec_tick && (unit_sel[`IWD_UNIT_SEC_BIT] ||
                       (sec_cnt == 6'(`IWD_SEC_PER_MIN - 1)));
    assign expire    = (state == iwd_pkg::IWD_COUNT) && unit_tick &&
                       (unit_cnt + 8'h01 == tmo_value);
    assign tmo_event = expire || force_pend;
    assign route     = config_reg[7:4];

    // ----------------------------------------
    // Next state computation
    // ----------------------------------------
    always_comb begin
        next_unit_sel   = unit_sel;
        next_tmo_value  = tmo_value;
        next_config_reg = config_reg;
        next_tmo_status = tmo_status;
        next_force_pend = 1'b0;
        next_irq_stat   = irq_stat;
        next_irq_mask   = irq_mask;
        next_tick_cnt   = tick_cnt + 32'h0000_0001;
        next_sec_cnt    = sec_cnt;
        next_unit_cnt   = unit_cnt;
        next_state      = state;
        next_prdata     = 32'h0000_0000;
        next_pready     = PSEL && !PENABLE;
        next_pslverr    = PSEL && !PENABLE && !mapped(PADDR);
        // Time base
        if (sec_tick) begin
            next_tick_cnt = 32'h0000_0000;
            if (unit_tick) begin
                next_sec_cnt = 6'h00;
            end else begin
                next_sec_cnt = sec_cnt + 6'h01;
            end
        end
        if (unit_tick && state == iwd_pkg::IWD_COUNT) begin
            next_unit_cnt = unit_cnt + 8'h01;
        end
        // Timeout
        if (expire) begin
            next_state = iwd_pkg::IWD_IDLE;
        end
        // Restart sources
        if (kick && tmo_value != 8'h00) begin
            next_state    = iwd_pkg::IWD_COUNT;
            next_unit_cnt = 8'h00;
            next_sec_cnt  = 6'h00;
            next_tick_cnt = 32'h0000_0000;
        end
        // Register reads
        if (PSEL && !PENABLE && !PWRITE) begin
            if (PADDR == `IWD_ADDR_UNIT) begin
                next_prdata = {24'h00_0000, unit_sel};
            end else if (PADDR == `IWD_ADDR_VALUE) begin
                next_prdata = {24'h00_0000, tmo_value};
            end else if (PADDR == `IWD_ADDR_CONFIG) begin
                next_prdata = {24'h00_0000, config_reg};
            end else if (PADDR == `IWD_ADDR_CTRL) begin
                next_prdata = {31'h0000_0000, tmo_status};
            end else if (PADDR == `IWD_ADDR_IRQ_STAT) begin
                next_prdata = {30'h0000_0000, irq_stat};
            end else if (PADDR == `IWD_ADDR_IRQ_MASK) begin
                next_prdata = {30'h0000_0000, irq_mask};
            end
        end
        // Read of status clears only the bits it returned
        // Events after the setup edge stay for the next read
        if (rd && PADDR == `IWD_ADDR_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~prdata_q[1:0];
        end
        // Register writes
        if (wr) begin
            if (PADDR == `IWD_ADDR_UNIT) begin
                next_unit_sel = PWDATA[7:0] & `IWD_UNIT_MASK;
            end else if (PADDR == `IWD_ADDR_VALUE) begin
                next_tmo_value = PWDATA[7:0];
                next_unit_cnt  = 8'h00;
                next_sec_cnt   = 6'h00;
                next_tick_cnt  = 32'h0000_0000;
                next_state     = (PWDATA[7:0] == 8'h00) ? iwd_pkg::IWD_IDLE
                                                        : iwd_pkg::IWD_COUNT;
            end else if (PADDR == `IWD_ADDR_CONFIG) begin
                next_config_reg = PWDATA[7:0] & `IWD_CFG_MASK;
            end else if (PADDR == `IWD_ADDR_CTRL) begin
                if (!PWDATA[`IWD_CTRL_STAT_BIT]) begin
                    next_tmo_status = 1'b0;
                end
                next_force_pend = PWDATA[`IWD_CTRL_FORCE_BIT];
            end else if (PADDR == `IWD_ADDR_IRQ_MASK) begin
                next_irq_mask = PWDATA[1:0];
            end
        end
        // Hardware sets win over clears
        if (tmo_event) begin
            next_tmo_status = 1'b1;
            next_irq_stat[0] = 1'b1;
        end
        if (kick) begin
            next_irq_stat[1] = 1'b1;
        end
        // IRQ routing, held while status is set
        next_irq_line = 16'h0000;
        if (next_tmo_status && route != 4'h0 && route != `IWD_IRQ_INVALID) begin
            next_irq_line[route] = 1'b1;
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            unit_sel   <= `IWD_RESET_VALUE;
            tmo_value  <= `IWD_RESET_VALUE;
            config_reg <= `IWD_RESET_VALUE;
            tmo_status <= 1'b0;
            force_pend <= 1'b0;
            irq_stat   <= 2'b00;
            irq_mask   <= 2'b00;
            tick_cnt   <= 32'h0000_0000;
            sec_cnt    <= 6'h00;
            unit_cnt   <= 8'h00;
            state      <= iwd_pkg::IWD_IDLE;
            prdata_q   <= 32'h0000_0000;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            irq_line_q <= 16'h0000;
            irq_q      <= 1'b0;
        end else begin
            unit_sel   <= next_unit_sel;
            tmo_value  <= next_tmo_value;
            config_reg <= next_config_reg;
            tmo_status <= next_tmo_status;
            force_pend <= next_force_pend;
            irq_stat   <= next_irq_stat;
            irq_mask   <= next_irq_mask;
            tick_cnt   <= next_tick_cnt;
            sec_cnt    <= next_sec_cnt;
            unit_cnt   <= next_unit_cnt;
            state      <= next_state;
            prdata_q   <= next_prdata;
            pready_q   <= next_pready;
            pslverr_q  <= next_pslverr;
            irq_line_q <= next_irq_line;
            irq_q      <= next_irq;
        end
    end

    // Outputs straight from the flops
    assign PRDATA   = prdata_q;
    assign PREADY   = pready_q;
    assign PSLVERR  = pslverr_q;
    assign IRQ_LINE = irq_line_q;
    assign IRQ      = irq_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!rst_n);

    // Register and timer checks
    a_zero_disables: assert property ((tmo_value == 8'h00) |-> state == iwd_pkg::IWD_IDLE)
        else $error("timer running while value is zero");

    a_value_restart: assert property ((wr && PADDR == `IWD_ADDR_VALUE)
                                      |=> unit_cnt == 8'h00)
        else $error("value write did not restart count");

    a_force_status: assert property (force_pend |=> tmo_status)
        else $error("forced timeout not flagged");

    a_force_clears: assert property ((force_pend && !(wr && PADDR == `IWD_ADDR_CTRL))
                                     |=> !force_pend)
        else $error("force bit did not self-clear");

    a_unit_rsvd: assert property (unit_sel[6:0] == 7'h00 && !config_reg[`IWD_CFG_RSVD_BIT])
        else $error("reserved bits nonzero");

    a_status_hold: assert property ((tmo_status && !(wr && PADDR == `IWD_ADDR_CTRL))
                                    |=> tmo_status)
        else $error("timeout status dropped without a clear");

    a_read_status: assert property ((PSEL && !PENABLE && !PWRITE && PADDR == `IWD_ADDR_CTRL)
                                    |=> PRDATA == {31'h0000_0000, $past(tmo_status)})
        else $error("status read returned wrong value");

    // Restart sources
    a_game_kick: assert property ((KICK.game && config_reg[0] && tmo_value != 8'h00 && !wr)
                                  |=> unit_cnt == 8'h00 && state == iwd_pkg::IWD_COUNT)
        else $error("game access did not restart");

    a_kbd_ignored: assert property ((KICK.kbd && !config_reg[1] && !KICK.game && !KICK.mouse
                                     && !wr && !sec_tick)
                                    |=> tick_cnt == $past(tick_cnt) + 32'h0000_0001)
        else $error("keyboard restart while disabled");

    a_mouse_kick: assert property ((KICK.mouse && config_reg[2] && tmo_value != 8'h00 && !wr)
                                   |=> unit_cnt == 8'h00)
        else $error("mouse did not restart");

    // Interrupt routing
    a_irq_route: assert property ((tmo_status && $past(route) == 4'h3)
                                  |-> IRQ_LINE == 16'h0008)
        else $error("irq not routed to line 3");

    a_irq_invalid: assert property ((route == 4'h0 || route == 4'h2)
                                    |=> IRQ_LINE == 16'h0000)
        else $error("irq driven while disabled");

    a_line_idle: assert property (!tmo_status |-> IRQ_LINE == 16'h0000)
        else $error("irq line high without timeout");

    a_irq_level: assert property (IRQ == |(irq_stat & irq_mask))
        else $error("summary interrupt wrong");

    // Time base and expiry
    a_expire_flag: assert property ((expire && !kick && !wr)
                                    |=> tmo_status && state == iwd_pkg::IWD_IDLE)
        else $error("expiry not flagged");

    a_count_grows: assert property ((state == iwd_pkg::IWD_COUNT && unit_tick && !expire
                                     && !kick && !wr) |=> unit_cnt == $past(unit_cnt) + 8'h01)
        else $error("unit count did not advance");

    a_minute_base: assert property ((!unit_sel[7] && sec_tick && sec_cnt != 6'h3B)
                                    |-> !unit_tick)
        else $error("minute base ticked early");

    a_sec_base: assert property ((unit_sel[`IWD_UNIT_SEC_BIT] && sec_tick) |-> unit_tick)
        else $error("second base missed a tick");

    // Main scenarios reached
    c_timeout: cover property (expire);
    c_forced: cover property (force_pend);
    c_kick: cover property (kick && state == iwd_pkg::IWD_COUNT);
    c_irq: cover property (IRQ);
    c_minute: cover property (unit_tick && !unit_sel[`IWD_UNIT_SEC_BIT]);
endmodule : iwd_watchdog
`default_nettype wire

/* dv/iwd_watchdog_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "iwd_cfg.svh"
module iwd_watchdog_tb_top;
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    localparam int unsigned SC    = 10;
    localparam int          LIMIT = 20000;
    logic               clock;
    logic               resetn;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    iwd_pkg::iwd_kick_s kick;
    logic [15:0]        irq_line;
    logic               irq;
    logic [31:0]        rdata;
    logic               rerr;
    int                 err_count;
    int                 checks_done;
    int                 cyc = 0;

    // Device under test with short second
    iwd_watchdog #(.SECOND_CYCLES(SC)) dut (
        .CLOCK(clock), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .KICK(kick), .IRQ_LINE(irq_line), .IRQ(irq)
    );

    // Clock at 250 MHz
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Cycle ceiling against hangs
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            complete_run();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer, held until pready at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdata   = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rdata, exp);
    endtask : rdchk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : wait_cyc

    task automatic pulse(input logic [2:0] v);
        @(posedge clock);
        kick <= iwd_pkg::iwd_kick_s'(v);
        @(posedge clock);
        kick <= 3'b000;
    endtask : pulse

    task complete_run();
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset values, reserved bits, unmapped access
    task automatic regs_scenario();
        logic [11:0] adr [6];
        adr = '{`IWD_ADDR_UNIT, `IWD_ADDR_VALUE, `IWD_ADDR_CONFIG, `IWD_ADDR_CTRL,
                `IWD_ADDR_IRQ_STAT, `IWD_ADDR_IRQ_MASK};
        foreach (adr[i]) rdchk(adr[i], 32'h0000_0000);
        wr(`IWD_ADDR_UNIT, 32'h0000_00FF);
        rdchk(`IWD_ADDR_UNIT, 32'h0000_0080);
        wr(`IWD_ADDR_CONFIG, 32'h0000_00FF);
        rdchk(`IWD_ADDR_CONFIG, 32'h0000_00F7);
        wr(`IWD_ADDR_VALUE, 32'h0000_00A5);
        rdchk(`IWD_ADDR_VALUE, 32'h0000_00A5);
        rdchk(12'h000, 32'h0000_0000);
        check({31'h0, rerr}, 32'h0000_0001);
        wr(`IWD_ADDR_VALUE, 32'h0000_0000);
        wr(`IWD_ADDR_CTRL, 32'h0000_0000);
    endtask : regs_scenario

    // Period of n cycles, then status and mapped line
    task automatic period_chk(input logic [7:0] unit, input logic [7:0] val, input int n);
        wr(`IWD_ADDR_CTRL, 32'h0000_0000);
        wr(`IWD_ADDR_CONFIG, 32'h0000_0050);
        wr(`IWD_ADDR_UNIT, {24'h0, unit});
        wr(`IWD_ADDR_VALUE, {24'h0, val});
        wait_cyc(n - 10);
        rdchk(`IWD_ADDR_CTRL, 32'h0000_0000);
        wait_cyc(14);
        rdchk(`IWD_ADDR_CTRL, 32'h0000_0001);
        check({16'h0, irq_line}, 32'h0000_0020);
    endtask : period_chk

    task automatic timeout_scenario();
        period_chk(8'h80, 8'h03, 3 * SC);
        period_chk(8'h80, 8'hFF, 255 * SC);
        period_chk(8'h00, 8'h01, 60 * SC);
        // Zero stops a running count
        wr(`IWD_ADDR_CTRL, 32'h0000_0000);
        wr(`IWD_ADDR_VALUE, 32'h0000_0001);
        wr(`IWD_ADDR_VALUE, 32'h0000_0000);
        wait_cyc(700);
        rdchk(`IWD_ADDR_CTRL, 32'h0000_0000);
        check({16'h0, irq_line}, 32'h0000_0000);
    endtask : timeout_scenario

    // Each restart source, enabled and disabled
    task automatic kick_scenario();
        wr(`IWD_ADDR_UNIT, 32'h0000_0080);
        for (int i = 0; i < 3; i++) begin
            for (int en = 0; en < 2; en++) begin
                wr(`IWD_ADDR_CTRL, 32'h0000_0000);
                wr(`IWD_ADDR_CONFIG, (en != 0) ? (32'h1 << i) : 32'h0);
                wr(`IWD_ADDR_VALUE, 32'h0000_0003);
                wait_cyc(20);
                pulse(3'b100 >> i);
                wait_cyc(12);
                rdchk(`IWD_ADDR_CTRL, (en != 0) ? 32'h0 : 32'h1);
                wait_cyc(25);
                rdchk(`IWD_ADDR_CTRL, 32'h0000_0001);
            end
        end
        // Value rewrite restarts the count
        wr(`IWD_ADDR_CTRL, 32'h0000_0000);
        wr(`IWD_ADDR_VALUE, 32'h0000_0003);
        wait_cyc(20);
        wr(`IWD_ADDR_VALUE, 32'h0000_0003);
        wait_cyc(14);
        rdchk(`IWD_ADDR_CTRL, 32'h0000_0000);
        wait_cyc(20);
        rdchk(`IWD_ADDR_CTRL, 32'h0000_0001);
        wr(`IWD_ADDR_VALUE, 32'h0000_0000);
    endtask : kick_scenario

    // Every route code through a forced timeout
    task automatic route_scenario();
        for (int k = 0; k < 16; k++) begin
            wr(`IWD_ADDR_CTRL, 32'h0000_0000);
            wr(`IWD_ADDR_CONFIG, 32'(k << 4));
            wr(`IWD_ADDR_CTRL, 32'h0000_0004);
            wait_cyc(3);
            check({16'h0, irq_line}, (k == 0 || k == 2) ? 32'h0 : 32'(1 << k));
            rdchk(`IWD_ADDR_CTRL, 32'h0000_0001);
        end
    endtask : route_scenario

    // Summary interrupt: raise, read-clear, mask
    task automatic irq_scenario();
        wr(`IWD_ADDR_CTRL, 32'h0000_0000);
        apb(1'b0, `IWD_ADDR_IRQ_STAT, 32'h0000_0000);
        wr(`IWD_ADDR_IRQ_MASK, 32'h0000_0001);
        wr(`IWD_ADDR_CTRL, 32'h0000_0004);
        wait_cyc(3);
        check({31'h0, irq}, 32'h0000_0001);
        rdchk(`IWD_ADDR_IRQ_STAT, 32'h0000_0001);
        wait_cyc(2);
        check({31'h0, irq}, 32'h0000_0000);
        rdchk(`IWD_ADDR_IRQ_STAT, 32'h0000_0000);
        wr(`IWD_ADDR_IRQ_MASK, 32'h0000_0000);
        wr(`IWD_ADDR_CTRL, 32'h0000_0000);
        wr(`IWD_ADDR_CTRL, 32'h0000_0004);
        wait_cyc(3);
        check({31'h0, irq}, 32'h0000_0000);
        rdchk(`IWD_ADDR_IRQ_STAT, 32'h0000_0001);
    endtask : irq_scenario

    // Mid-run reset while counting returns registers to zero
    task automatic reset_scenario();
        wr(`IWD_ADDR_UNIT, 32'h0000_0080);
        wr(`IWD_ADDR_CONFIG, 32'h0000_0037);
        wr(`IWD_ADDR_VALUE, 32'h0000_0002);
        @(posedge clock);
        resetn <= 1'b0;
        wait_cyc(3);
        resetn <= 1'b1;
        wait_cyc(3);
        rdchk(`IWD_ADDR_UNIT, 32'h0000_0000);
        rdchk(`IWD_ADDR_VALUE, 32'h0000_0000);
        rdchk(`IWD_ADDR_CONFIG, 32'h0000_0000);
        wait_cyc(30);
        rdchk(`IWD_ADDR_CTRL, 32'h0000_0000);
        check({16'h0, irq_line}, 32'h0000_0000);
    endtask : reset_scenario

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        resetn      = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h0000_0000;
        kick        = 3'b000;
        err_count   = 0;
        checks_done = 0;
        wait_cyc(3);
        resetn <= 1'b1;
        wait_cyc(3);
        regs_scenario();
        timeout_scenario();
        kick_scenario();
        route_scenario();
        irq_scenario();
        reset_scenario();
        complete_run();
    end
endmodule : iwd_watchdog_tb_top
`default_nettype wire
